// *** hdl/burst_order.sv ***
// Column order of one burst position for reads and writes.
`timescale 1ns/100ps
module burst_order (
	input wire logic [2:0] start,
	input wire logic [2:0] pos,
	input wire logic interleave,
	input wire logic is_write,
	input wire logic chop,
	output logic [2:0] col
);
	// Writes ignore the low start bits; reads follow the burst type.
	always_comb begin
		if (is_write && chop) begin
			col = {start[2], pos[1:0]};
		end else if (is_write) begin
			col = pos;
		end else if (interleave) begin
			col = start ^ pos;
		end else begin
			col = {start[2] ^ pos[2], 2'(start[1:0] + pos[1:0])};
		end
	end
endmodule // burst_order

// *** hdl/mode_burst_ctrl.sv ***
// Mode register decode, burst sequencing and loop control of the memory device.
// What this block does
// - Bank 10 mode set writes refresh register.
// - Write termination always; dynamic enable none while leveling.
// - Partial refresh loses outside data on entry.
// - Bank 11 mode set writes readout register.
// - Pattern off ignores location bits.
// - Pattern on makes reads return pattern.
// - Burst length fixed four, eight, or flying.
// - Fixed chop writes commit two clocks early.
// - Flying chop writes commit like eight.
// - Sequential reads wrap inside four-column group.
// - Interleaved column is start xor position.
// - Chop reads float last four positions.
// - Chop writes use start bit two only.
// - Eight writes always go zero to seven.
// - Self refresh turns the loop off.
// - Writes never wait for loop lock.
// - Loop disable bit holds loop off.
// - Loop off supports latency six only.
// - Loop off read reference one cycle earlier.
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module mode_burst_ctrl import mode_burst_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cs_n,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_en_n,
	input wire logic clk_enable,
	input wire logic [2:0] bank_addr,
	input wire logic [15:0] addr,
	output logic [2:0] col_first,
	output logic [2:0] col_second,
	output logic dq_oe_n,
	output logic write_commit,
	output logic strobe_ref,
	output logic pattern_sel,
	output logic [1:0] pattern_loc,
	output logic [7:0] pattern_data,
	output logic term_write_on,
	output logic term_dynamic_en,
	output logic loop_enabled,
	output logic loop_locked,
	output logic [2:0] partial_array_self_refresh
);
	// Complete block state.
	typedef struct packed {
		logic [15:0] burst_latency_reg;
		logic [15:0] loop_and_drive_config_reg;
		logic [15:0] refresh_termination_latency_reg;
		logic [15:0] readout_control_reg;
		logic ctrl_en;
		logic [7:0] pattern;
		logic self_ref;
		logic [9:0] lock_cnt;
		logic locked;
		phase_type phase;
		logic is_write;
		logic chop;
		logic early;
		logic [2:0] start;
		logic [4:0] lat_cnt;
		logic [1:0] beat;
		logic [4:0] flags;
		logic [31:0] prdata;
		logic [2:0] col_a;
		logic [2:0] col_b;
		logic dq_oe_n;
		logic write_commit;
		logic strobe_ref;
		logic pattern_sel;
		logic term_write_on;
	} state_type;

	// Reset image: decode enabled, outputs floating, engine idle.
	localparam state_type STATE_RST = '{ctrl_en: CTRL_EN_RST, pattern: PATTERN_RST,
		dq_oe_n: 1'b1, phase: PH_IDLE, default: '0};

	state_type ff; // Registered state.
	state_type nxt; // Next state.
	logic [23:0] pins_raw; // Command pins as they arrive.
	logic [23:0] pins_s; // Command pins after synchronisation.
	logic [3:0] cmd_s; // Chip select and the three strobes.
	logic cke_s; // Synchronised clock enable.
	logic [2:0] ba_s; // Synchronised bank address.
	logic [15:0] addr_s; // Synchronised address.
	logic mrs_hit; // Mode register set seen.
	logic read_hit; // Read command seen.
	logic write_hit; // Write command seen.
	logic sr_entry; // Self refresh entry seen.
	logic idle; // Burst engine free.
	logic rd_go; // Read accepted.
	logic wr_go; // Write accepted.
	logic loop_off; // Loop disabled by software.
	logic loop_on; // Loop running.
	logic [15:0] keep_mask; // Writable bits of the addressed mode register.
	logic [4:0] rd_lat; // Read latency setting in clocks.
	logic [4:0] wr_lat; // Write latency setting in clocks.
	logic [4:0] add_lat; // Additive latency setting in clocks.
	logic [2:0] ord_a; // Column of the even position.
	logic [2:0] ord_b; // Column of the odd position.
	logic apb_mapped; // Address hits a register.
	logic [31:0] rd_mux; // Read data for the addressed register.

	// Pins come from the controller's clock; resync before use.
	assign pins_raw = {cs_n, row_strobe_n, col_strobe_n, write_en_n, clk_enable, bank_addr, addr};

	pin_sync #(.W(24), .INIT({4'hf, 20'h00000})) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.din(pins_raw),
		.dout(pins_s)
	);

	assign cmd_s = pins_s[23:20];
	assign cke_s = pins_s[19];
	assign ba_s = pins_s[18:16];
	assign addr_s = pins_s[15:0];

	// Command decode; commands count with clock enable high, self refresh entry with it low.
	assign mrs_hit = ff.ctrl_en && cke_s && (cmd_s == 4'h0);
	assign read_hit = ff.ctrl_en && cke_s && (cmd_s == 4'h5);
	assign write_hit = ff.ctrl_en && cke_s && (cmd_s == 4'h4);
	assign sr_entry = ff.ctrl_en && !cke_s && (cmd_s == 4'h1) && !ff.self_ref;
	assign idle = (ff.phase == PH_IDLE);
	assign rd_go = read_hit && idle;
	assign wr_go = write_hit && idle;

	// Loop state follows the disable bit and self refresh.
	assign loop_off = ff.loop_and_drive_config_reg[LOOP_OFF_BIT];
	assign loop_on = !loop_off && !ff.self_ref;

	// Latencies decoded from the mode registers.
	assign rd_lat = RD_LAT_BASE + {2'b00, ff.burst_latency_reg[RDLAT_LSB +: 3]};
	assign wr_lat = WR_LAT_BASE + {2'b00, ff.refresh_termination_latency_reg[WRLAT_LSB +: 3]};

	// Additive latency: off, one less or two less than read latency.
	always_comb begin
		unique case (ff.loop_and_drive_config_reg[ADDLAT_LSB +: 2])
			2'b01: begin
				add_lat = 5'(rd_lat - 5'h01);
			end
			2'b10: begin
				add_lat = 5'(rd_lat - 5'h02);
			end
			default: begin
				add_lat = 5'h00;
			end
		endcase
	end

	// Writable bits of the register addressed by the bank bits.
	always_comb begin
		unique case (ba_s[1:0])
			2'b00: begin
				keep_mask = BURST_KEEP;
			end
			2'b01: begin
				keep_mask = LOOP_KEEP;
			end
			2'b10: begin
				keep_mask = REFRESH_KEEP;
			end
			default: begin
				keep_mask = READOUT_KEEP;
			end
		endcase
	end

	// Column order for the two positions of the current clock.
	burst_order u_ord_a (
		.start(ff.start),
		.pos({ff.beat, 1'b0}),
		.interleave(ff.burst_latency_reg[BT_BIT]),
		.is_write(ff.is_write),
		.chop(ff.chop),
		.col(ord_a)
	);

	burst_order u_ord_b (
		.start(ff.start),
		.pos({ff.beat, 1'b1}),
		.interleave(ff.burst_latency_reg[BT_BIT]),
		.is_write(ff.is_write),
		.chop(ff.chop),
		.col(ord_b)
	);

	// APB address decode and read data selection.
	always_comb begin
		apb_mapped = 1'b1;
		rd_mux = 32'h00000000;
		case (paddr)
			CTRL_OFS: begin
				rd_mux = {31'h00000000, ff.ctrl_en};
			end
			STATUS_OFS: begin
				rd_mux = {20'h00000, !idle, ff.self_ref, ff.locked, loop_on, 3'h0, ff.flags};
			end
			BURST_REG_OFS: begin
				rd_mux = {16'h0000, ff.burst_latency_reg};
			end
			LOOP_REG_OFS: begin
				rd_mux = {16'h0000, ff.loop_and_drive_config_reg};
			end
			REFRESH_REG_OFS: begin
				rd_mux = {16'h0000, ff.refresh_termination_latency_reg};
			end
			READOUT_REG_OFS: begin
				rd_mux = {16'h0000, ff.readout_control_reg};
			end
			PATTERN_OFS: begin
				rd_mux = {24'h000000, ff.pattern};
			end
			default: begin
				apb_mapped = 1'b0;
			end
		endcase
	end

	// Next state: bus, mode registers, loop and burst engine.
	always_comb begin
		nxt = ff;
		nxt.write_commit = 1'b0;
		nxt.strobe_ref = 1'b0;
		// Read data is latched in the setup cycle and shown in the access cycle.
		if (psel && !penable) begin
			nxt.prdata = apb_mapped ? rd_mux : 32'h00000000;
		end
		// Software writes; status flags clear by writing one.
		if (psel && penable && pwrite) begin
			case (paddr)
				CTRL_OFS: begin
					nxt.ctrl_en = pwdata[0];
				end
				STATUS_OFS: begin
					nxt.flags = ff.flags & ~pwdata[4:0];
				end
				PATTERN_OFS: begin
					nxt.pattern = pwdata[7:0];
				end
				default: begin
					nxt.ctrl_en = ff.ctrl_en;
				end
			endcase
		end
		// Mode register set: the bank bits pick the register, reserved bits drop.
		if (mrs_hit) begin
			unique case (ba_s[1:0])
				2'b00: begin
					nxt.burst_latency_reg = addr_s & BURST_KEEP;
				end
				2'b01: begin
					nxt.loop_and_drive_config_reg = addr_s & LOOP_KEEP;
				end
				2'b10: begin
					nxt.refresh_termination_latency_reg = addr_s & REFRESH_KEEP;
				end
				default: begin
					nxt.readout_control_reg = addr_s & READOUT_KEEP;
				end
			endcase
			if (ba_s[2] || ((addr_s & ~keep_mask) != 16'h0000)) begin
				nxt.flags[FLAG_RSVD] = 1'b1;
			end
		end
		// Self refresh entry and exit; partial refresh may drop data here.
		if (sr_entry) begin
			nxt.self_ref = 1'b1;
			if (ff.refresh_termination_latency_reg[PARTIAL_LSB +: 3] != 3'h0) begin
				nxt.flags[FLAG_PART_LOSS] = 1'b1;
			end
		end else if (ff.self_ref && cke_s) begin
			nxt.self_ref = 1'b0;
		end
		// Lock timer runs from a loop reset while the loop is on.
		// Lock drops at the very edge that turns the loop off, never one clock later.
		if (!loop_on || sr_entry ||
			(mrs_hit && (ba_s[1:0] == 2'b01) && addr_s[LOOP_OFF_BIT])) begin
			nxt.lock_cnt = 10'h000;
			nxt.locked = 1'b0;
		end else if (mrs_hit && (ba_s[1:0] == 2'b00) && addr_s[LOOP_RESET_BIT]) begin
			nxt.lock_cnt = LOCK_CYCLES;
			nxt.locked = 1'b0;
		end else if (ff.lock_cnt != 10'h000) begin
			nxt.lock_cnt = 10'(ff.lock_cnt - 10'h001);
			nxt.locked = (ff.lock_cnt == 10'h001);
		end
		// A command that finds the engine busy is dropped and flagged.
		if ((read_hit || write_hit) && !idle) begin
			nxt.flags[FLAG_OVERRUN] = 1'b1;
		end
		// Accept a read or write and load its latency.
		if (rd_go || wr_go) begin
			nxt.phase = PH_WAIT;
			nxt.is_write = wr_go;
			nxt.start = addr_s[2:0];
			nxt.beat = 2'b00;
			unique case (ff.burst_latency_reg[BL_LSB +: 2])
				BL_FIXED4: begin
					nxt.chop = 1'b1;
					nxt.early = 1'b1;
				end
				BL_OTF: begin
					nxt.chop = !addr_s[OTF_ADDR_BIT];
					nxt.early = 1'b0;
				end
				default: begin
					nxt.chop = 1'b0;
					nxt.early = 1'b0;
				end
			endcase
			if (wr_go) begin
				nxt.lat_cnt = 5'(add_lat + wr_lat - 5'h01);
			end else if (loop_off) begin
				nxt.lat_cnt = 5'(add_lat + rd_lat - 5'h02);
			end else begin
				nxt.lat_cnt = 5'(add_lat + rd_lat - 5'h01);
			end
			if (rd_go && loop_on && !ff.locked) begin
				nxt.flags[FLAG_EARLY_READ] = 1'b1;
			end
			if (loop_off && (rd_lat != OFF_LAT_ONLY || wr_lat != OFF_LAT_ONLY)) begin
				nxt.flags[FLAG_OFF_LAT] = 1'b1;
			end
		end
		// Latency wait; the read strobe reference marks the slot start.
		if (ff.phase == PH_WAIT) begin
			if (ff.lat_cnt == 5'h01) begin
				nxt.phase = PH_SLOT;
				nxt.strobe_ref = !ff.is_write;
			end else begin
				nxt.lat_cnt = 5'(ff.lat_cnt - 5'h01);
			end
		end
		// Data slot: two positions per clock for four clocks.
		nxt.dq_oe_n = 1'b1;
		nxt.pattern_sel = 1'b0;
		nxt.term_write_on = 1'b0;
		if (ff.phase == PH_SLOT) begin
			nxt.col_a = ord_a;
			nxt.col_b = ord_b;
			nxt.dq_oe_n = ff.is_write || (ff.chop && ff.beat[1]);
			nxt.pattern_sel = !ff.is_write && ff.readout_control_reg[PATTERN_EN_BIT];
			nxt.term_write_on = ff.is_write &&
				(ff.refresh_termination_latency_reg[TERM_WR_LSB +: 2] != 2'b00);
			nxt.write_commit = ff.is_write && (ff.beat == (ff.early ? EARLY_BEAT : LAST_BEAT));
			if (ff.beat == LAST_BEAT) begin
				nxt.phase = PH_IDLE;
			end else begin
				nxt.beat = 2'(ff.beat + 2'b01);
			end
		end
	end

	// State register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ff <= STATE_RST;
		end else begin
			ff <= nxt;
		end
	end

	// Zero wait state slave; error only on unmapped addresses.
	assign pready = 1'b1;
	assign pslverr = psel && penable && !apb_mapped;
	assign prdata = ff.prdata;
	assign col_first = ff.col_a;
	assign col_second = ff.col_b;
	assign dq_oe_n = ff.dq_oe_n;
	assign write_commit = ff.write_commit;
	assign strobe_ref = ff.strobe_ref;
	assign pattern_sel = ff.pattern_sel;
	assign pattern_data = ff.pattern;
	// Location is ignored while the pattern readout is off.
	assign pattern_loc = ff.readout_control_reg[PATTERN_EN_BIT] ?
		ff.readout_control_reg[1:0] : 2'b00;
	assign term_write_on = ff.term_write_on;
	// Dynamic termination only outside write leveling.
	assign term_dynamic_en = !ff.loop_and_drive_config_reg[LEVEL_BIT] &&
		(ff.refresh_termination_latency_reg[TERM_WR_LSB +: 2] != 2'b00);
	assign loop_enabled = loop_on;
	assign loop_locked = ff.locked;
	assign partial_array_self_refresh = ff.refresh_termination_latency_reg[PARTIAL_LSB +: 3];

	// Checks on the block's own behaviour.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	refresh_decode_a: assert property (
		(mrs_hit && ba_s[1:0] == 2'b10) |=>
		ff.refresh_termination_latency_reg == ($past(addr_s) & REFRESH_KEEP))
		else $error("refresh register not loaded");
	readout_decode_a: assert property (
		(mrs_hit && ba_s[1:0] == 2'b11) |=> ff.readout_control_reg == ($past(addr_s) & READOUT_KEEP))
		else $error("readout register not loaded");
	pattern_read_a: assert property (
		(ff.phase == PH_SLOT && !ff.is_write && ff.readout_control_reg[PATTERN_EN_BIT]) |=> pattern_sel)
		else $error("pattern not selected on read");
	chop_float_a: assert property (
		(ff.phase == PH_SLOT && !ff.is_write && ff.chop && ff.beat == 2'b01) |=> !dq_oe_n ##1 dq_oe_n [*2])
		else $error("chop read drives late positions");
	early_commit_a: assert property (
		(ff.phase == PH_SLOT && ff.is_write && ff.early && ff.beat == 2'b00) |=>
		!write_commit ##1 write_commit)
		else $error("fixed chop write not advanced");
	late_commit_a: assert property (
		(ff.phase == PH_SLOT && ff.is_write && !ff.early && ff.beat == 2'b00) |=>
		!write_commit [*3] ##1 write_commit)
		else $error("write commit not at slot end");
	interleave_col_a: assert property (
		(ff.phase == PH_SLOT && !ff.is_write && ff.burst_latency_reg[BT_BIT]) |=>
		col_first == ($past(ff.start) ^ {$past(ff.beat), 1'b0}))
		else $error("interleaved column wrong");
	seq_group_a: assert property (
		(ff.phase == PH_SLOT && !ff.is_write && !ff.burst_latency_reg[BT_BIT] && !ff.beat[1]) |=>
		col_second[2] == $past(ff.start[2]))
		else $error("sequential read left its group");
	write_order_a: assert property (
		(ff.phase == PH_SLOT && ff.is_write && !ff.chop) |=> col_second == {$past(ff.beat), 1'b1})
		else $error("eight write out of order");
	loop_gate_a: assert property (
		(ff.self_ref || loop_off) |-> !loop_enabled && !loop_locked)
		else $error("loop on in self refresh or disabled");
	off_latency_a: assert property (
		(rd_go && loop_off) |=> ff.lat_cnt == 5'($past(add_lat + rd_lat) - 5'h02))
		else $error("loop off read reference wrong");

	cover_chop_read: cover property (ff.phase == PH_SLOT && !ff.is_write && ff.chop);
	cover_off_read: cover property (rd_go && loop_off);
	cover_lock_done: cover property (!ff.locked ##1 ff.locked);
endmodule // mode_burst_ctrl

// *** hdl/mode_burst_pkg.sv ***
// Shared constants and types of the mode register and burst control block.
package mode_burst_pkg;
	// APB register byte offsets.
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] BURST_REG_OFS = 8'h08;
	localparam logic [7:0] LOOP_REG_OFS = 8'h0c;
	localparam logic [7:0] REFRESH_REG_OFS = 8'h10;
	localparam logic [7:0] READOUT_REG_OFS = 8'h14;
	localparam logic [7:0] PATTERN_OFS = 8'h18;
	// Reset values of the software registers.
	localparam logic CTRL_EN_RST = 1'b1;
	localparam logic [7:0] PATTERN_RST = 8'h55;
	// Address bits kept by each mode register; the rest are reserved.
	localparam logic [15:0] BURST_KEEP = 16'h1fff;
	localparam logic [15:0] LOOP_KEEP = 16'h12ff;
	localparam logic [15:0] REFRESH_KEEP = 16'h06ff;
	localparam logic [15:0] READOUT_KEEP = 16'h0007;
	// Field positions inside the mode registers.
	localparam int BL_LSB = 0;
	localparam int BT_BIT = 3;
	localparam int RDLAT_LSB = 4;
	localparam int LOOP_RESET_BIT = 8;
	localparam int LOOP_OFF_BIT = 0;
	localparam int ADDLAT_LSB = 3;
	localparam int LEVEL_BIT = 7;
	localparam int PARTIAL_LSB = 0;
	localparam int WRLAT_LSB = 3;
	localparam int TERM_WR_LSB = 9;
	localparam int PATTERN_EN_BIT = 2;
	localparam int OTF_ADDR_BIT = 12;
	// Burst length field codes.
	localparam logic [1:0] BL_FIXED8 = 2'b00;
	localparam logic [1:0] BL_OTF = 2'b01;
	localparam logic [1:0] BL_FIXED4 = 2'b10;
	// Latency field bases and the only latency supported with the loop off.
	localparam logic [4:0] RD_LAT_BASE = 5'h04;
	localparam logic [4:0] WR_LAT_BASE = 5'h05;
	localparam logic [4:0] OFF_LAT_ONLY = 5'h06;
	// Loop lock time in command clocks; pclk is the command clock.
	localparam int LOCK_TIME_NCK = 512;
	localparam logic [9:0] LOCK_CYCLES = 10'(LOCK_TIME_NCK);
	// Burst slot of four clocks, two positions per clock.
	localparam int SLOT_CLOCKS = 4;
	localparam int CHOP_ADVANCE = 2;
	localparam logic [1:0] LAST_BEAT = 2'(SLOT_CLOCKS - 1);
	localparam logic [1:0] EARLY_BEAT = 2'(SLOT_CLOCKS - 1 - CHOP_ADVANCE);
	// Sticky flag and status bit positions.
	localparam int FLAG_RSVD = 0;
	localparam int FLAG_EARLY_READ = 1;
	localparam int FLAG_PART_LOSS = 2;
	localparam int FLAG_OFF_LAT = 3;
	localparam int FLAG_OVERRUN = 4;
	localparam int STAT_LOOP_ON = 8;
	// Burst engine phases.
	typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_WAIT = 2'b01, PH_SLOT = 2'b10} phase_type;
endpackage

// *** hdl/pin_sync.sv ***
// Two flip-flop synchroniser for a group of pins.
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	// First stage; read only by the second stage.
	logic [W-1:0] meta_ff;

	// Both stages reset to the idle pin level.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= INIT;
			dout <= INIT;
		end else begin
			meta_ff <= din;
			dout <= meta_ff;
		end
	end
endmodule // pin_sync

// *** verification/ddr3_mode_burst_dll_ctrl_tb.sv ***
// Self-checking testbench of the mode register and burst control block.
`timescale 1ns/100ps
module ddr3_mode_burst_dll_ctrl_tb import mode_burst_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, pattern_data;
	logic [31:0] pwdata, prdata, rd;
	logic cs_n, row_strobe_n, col_strobe_n, write_en_n, clk_enable, dq_oe_n, er;
	logic write_commit, strobe_ref, pattern_sel, loop_enabled, loop_locked;
	logic term_write_on, term_dynamic_en;
	logic [2:0] bank_addr, col_first, col_second, partial_array_self_refresh;
	logic [15:0] addr, rv;
	logic [1:0] pattern_loc, bl;
	logic sr[32], cm[32], oe[32], ps[32], tw[32];
	logic [2:0] c1[32], c2[32], st;
	logic il, ot, ch;
	int seed = 14, err_total = 0, n_checks = 0, lr, lr2, n, k, j;
	mode_burst_ctrl i_dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .cs_n, .row_strobe_n, .col_strobe_n, .write_en_n,
		.clk_enable, .bank_addr, .addr, .col_first, .col_second, .dq_oe_n, .write_commit,
		.strobe_ref, .pattern_sel, .pattern_loc, .pattern_data, .term_write_on,
		.term_dynamic_en, .loop_enabled, .loop_locked, .partial_array_self_refresh);
	mem_ctl_model i_ctl(.pclk, .cs_n, .row_strobe_n, .col_strobe_n, .write_en_n,
		.clk_enable, .bank_addr, .addr);
	// Clock of 40 ns period.
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// Compares one value and counts it.
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// One APB transfer: setup, access until pready, then release.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Expected column of one burst position.
	function automatic logic [2:0] ecol(logic [2:0] s, logic [2:0] p, logic wr, logic c);
		if (wr) return c ? {s[2], p[1:0]} : p;
		return il ? s ^ p : {s[2] ^ p[2], s[1:0] + p[1:0]};
	endfunction
	// Issues a read or write and records the outputs of the following clocks.
	task automatic run(input logic [3:0] c, input logic [15:0] a);
		i_ctl.cmd(c, 3'h0, a, 1'b1);
		lr = 0;
		n = 0;
		for (int i = 1; i < 28; i++) begin
			#1;
			{sr[i], cm[i], oe[i], ps[i], tw[i], c1[i], c2[i]} = {strobe_ref, write_commit,
				dq_oe_n, pattern_sel, term_write_on, col_first, col_second};
			if (strobe_ref === 1'b1 || write_commit === 1'b1) begin
				n++;
				lr = i;
			end
			@(posedge pclk);
		end
	endtask
	// Watchdog against a hang.
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		end_sim();
	end
	// Main sequence.
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, CTRL_OFS, 0);
		chk("ctrl reset", rd, 32'h1);
		apb(1'b0, PATTERN_OFS, 0);
		chk("pattern reset", rd, {24'h0, PATTERN_RST});
		chk("pattern data", pattern_data, PATTERN_RST);
		apb(1'b0, 8'h1c, 0);
		chk("unmapped", {er, rd[30:0]}, 32'h80000000);
		repeat (3) begin
			rv = 16'($random(seed));
			i_ctl.mrs(3'h2, rv);
			chk("refresh field", partial_array_self_refresh, rv[2:0]);
			apb(1'b0, REFRESH_REG_OFS, 0);
			chk("refresh view", rd, {16'h0, rv & REFRESH_KEEP});
		end
		i_ctl.mrs(3'h2, 16'h0000);
		i_ctl.mrs(3'h3, 16'h0003);
		chk("loc ignored", pattern_loc, 2'b00);
		// The reads below come only after the loop has locked.
		i_ctl.mrs(3'h0, 16'h0100);
		for (k = 0; k < 700 && loop_locked !== 1'b1; k++) @(posedge pclk);
		for (k = 0; k < 6; k++) begin
			bl = (k < 2) ? BL_FIXED8 : (k < 4) ? BL_OTF : BL_FIXED4;
			il = k[0];
			st = $random(seed);
			ot = $random(seed);
			ch = (bl == BL_FIXED4) || (bl == BL_OTF && !ot);
			i_ctl.mrs(3'h0, {9'h0, 3'h1, il, 1'b0, bl});
			run(4'b0101, {3'h0, ot, 9'h0, st});
			chk("strobe pulses", n, 1);
			lr2 = lr;
			for (j = 0; j < 4; j++) begin
				chk("rd oe", oe[lr2 + 1 + j], ch && j > 1);
				if (!(ch && j > 1)) begin
					chk("rd col a", c1[lr2 + 1 + j], ecol(st, 2 * j, 0, ch));
					chk("rd col b", c2[lr2 + 1 + j], ecol(st, 2 * j + 1, 0, ch));
					chk("rd no pattern", ps[lr2 + 1 + j], 0);
				end
			end
			run(4'b0100, {3'h0, ot, 9'h0, st});
			chk("commit at", lr, lr2 + ((bl == BL_FIXED4) ? 2 : 4));
			for (j = 0; j < 2; j++) begin
				chk("wr col a", c1[lr2 + 1 + j], ecol(st, 2 * j, 1, ch));
				chk("wr col b", c2[lr2 + 1 + j], ecol(st, 2 * j + 1, 1, ch));
			end
		end
		i_ctl.mrs(3'h3, 16'h0006);
		chk("loc on", pattern_loc, 2'b10);
		run(4'b0101, 16'h0000);
		chk("pattern read", ps[lr + 1], 1);
		i_ctl.mrs(3'h3, 16'h0000);
		i_ctl.mrs(3'h2, 16'h0008);
		i_ctl.mrs(3'h0, 16'h0120);
		run(4'b0100, 16'h0000);
		chk("wr unlocked", {loop_locked, n[1:0]}, 3'b001);
		for (k = 0; k < 700 && loop_locked !== 1'b1; k++) @(posedge pclk);
		chk("locked", loop_locked, 1);
		run(4'b0101, 16'h0000);
		lr2 = lr;
		apb(1'b1, STATUS_OFS, 32'h1f);
		i_ctl.mrs(3'h1, 16'h0001);
		chk("loop off", loop_enabled, 0);
		run(4'b0101, 16'h0000);
		chk("off strobe", lr, lr2 - 1);
		apb(1'b0, STATUS_OFS, 0);
		chk("off latency six", rd[FLAG_OFF_LAT], 0);
		i_ctl.mrs(3'h2, 16'h0000);
		run(4'b0101, 16'h0000);
		apb(1'b0, STATUS_OFS, 0);
		chk("off latency flag", rd[FLAG_OFF_LAT], 1);
		i_ctl.mrs(3'h1, 16'h0000);
		chk("loop on", loop_enabled, 1);
		i_ctl.cmd(4'b0001, 3'h0, 16'h0000, 1'b0);
		repeat (5) @(posedge pclk);
		chk("sr loop", loop_enabled, 0);
		i_ctl.cmd(4'hf, 3'h0, 16'h0000, 1'b1);
		repeat (5) @(posedge pclk);
		chk("sr exit", loop_enabled, 1);
		i_ctl.mrs(3'h2, 16'h0200);
		chk("dyn term", term_dynamic_en, 1);
		run(4'b0100, 16'h0000);
		chk("write term", {tw[lr], tw[lr + 1]}, 2'b10);
		i_ctl.mrs(3'h1, 16'h0080);
		chk("level no dyn term", term_dynamic_en, 0);
		end_sim();
	end
endmodule // ddr3_mode_burst_dll_ctrl_tb

// *** verification/mem_ctl_model.sv ***
// Memory controller model that drives the command pins of the device.
`timescale 1ns/100ps
module mem_ctl_model import mode_burst_pkg::*; (
	input wire logic pclk,
	output logic cs_n,
	output logic row_strobe_n,
	output logic col_strobe_n,
	output logic write_en_n,
	output logic clk_enable,
	output logic [2:0] bank_addr,
	output logic [15:0] addr
);
	// Idle pins at time zero: deselected, clock enable high.
	initial begin
		{cs_n, row_strobe_n, col_strobe_n, write_en_n} = 4'hf;
		clk_enable = 1'b1;
		bank_addr = 3'h0;
		addr = 16'h0000;
	end
	// One command for one clock; afterwards deselect, with bank and address showing the inverse value.
	task automatic cmd(input logic [3:0] c, input logic [2:0] ba, input logic [15:0] a,
		input logic cke);
		@(posedge pclk);
		{cs_n, row_strobe_n, col_strobe_n, write_en_n} <= c;
		bank_addr <= ba;
		addr <= a;
		clk_enable <= cke;
		@(posedge pclk);
		{cs_n, row_strobe_n, col_strobe_n, write_en_n} <= 4'hf;
		bank_addr <= ~ba;
		addr <= ~a;
	endtask
	// Mode set with reserved bits zeroed, then a settling gap.
	task automatic mrs(input logic [2:0] ba, input logic [15:0] v);
		logic [15:0] keep;
		keep = (ba == 3'h0) ? BURST_KEEP : (ba == 3'h1) ? LOOP_KEEP :
			(ba == 3'h2) ? REFRESH_KEEP : READOUT_KEEP;
		cmd(4'h0, ba, v & keep, 1'b1);
		repeat (4) @(posedge pclk);
	endtask
endmodule // mem_ctl_model
